// ### pkg/csi_pkg.sv
// constants, field layouts and types for the capacitance sensor serial slave
package csi_pkg;

  // 7-bit bus address; the full address byte is 0x90 for write and 0x91 for read
  localparam logic [6:0] CSI_DEV_ADDR     = 7'h48;
  localparam logic       CSI_DIR_WRITE    = 1'b0;

  // register pointer values
  localparam logic [7:0] CSI_PTR_RESET    = 8'h00;
  localparam logic [7:0] CSI_OFS_CH1_DAC  = 8'h11;
  localparam logic [7:0] CSI_OFS_CH2_DAC  = 8'h12;
  localparam logic [7:0] CSI_OFS_SERIAL0  = 8'h13;
  localparam logic [7:0] CSI_OFS_SERIAL1  = 8'h14;
  localparam logic [7:0] CSI_OFS_SERIAL2  = 8'h15;
  localparam logic [7:0] CSI_OFS_SERIAL3  = 8'h16;
  localparam logic [7:0] CSI_OFS_CHIP_IDENTIFICATION  = 8'h17;
  localparam logic [7:0] CSI_UNMAPPED_VAL = 8'h00;

  // offset dac register reset: enable and auto-adjust set, zero code
  localparam logic [7:0] CSI_DAC_RESET    = 8'hc0;
  localparam logic [5:0] CSI_DAC_CODE_MAX = 6'h3f;
  localparam logic [5:0] CSI_DAC_CODE_MIN = 6'h00;

  // bits per serial byte, ninth clock carries the acknowledge
  localparam logic [3:0] CSI_BYTE_BITS    = 4'h8;
  localparam int         CSI_CHANNELS     = 2;

  // offset dac control register: bit 7 enable, bit 6 auto-adjust, bits 5..0 code
  typedef struct packed {
    logic       offset_dac_enable;
    logic       offset_auto_adjust;
    logic [5:0] offset_dac_code;
  } csi_dac_type;

  typedef enum {
    CSI_IDLE,
    CSI_ADDR,
    CSI_ADDR_ACK,
    CSI_PTR,
    CSI_WR_ACK,
    CSI_WDATA,
    CSI_RDATA,
    CSI_RD_ACK
  } csi_state_type;

endpackage

// ### hw/csi_dac_adjust.sv
// automatic offset dac code adjustment for one channel
`timescale 1ns/1ps
`default_nettype none
module csi_dac_adjust
  import csi_pkg::*;
#(
  parameter int AVG_W = 16
) (
  input  wire logic [AVG_W-1:0] avg_i,
  input  wire logic             avg_valid_i,
  input  wire logic             adaptive_i,
  input  wire logic [5:0]       step_i,
  input  wire csi_dac_type      cur_i,
  output csi_dac_type           next_o,
  output logic                  change_o
);

  localparam logic [AVG_W-1:0] QUARTER    = AVG_W'(1) << (AVG_W - 2);
  localparam logic [AVG_W-1:0] THREE_QTR  = QUARTER + (QUARTER << 1);

  wire       active   = adaptive_i & cur_i.offset_auto_adjust & avg_valid_i;
  wire       go_up    = active & (avg_i > THREE_QTR);
  wire       go_down  = active & (avg_i < QUARTER);
  wire [6:0] sum      = {1'b0, cur_i.offset_dac_code} + {1'b0, step_i};
  wire       sat_hi   = sum > {1'b0, CSI_DAC_CODE_MAX};
  wire       sat_lo   = cur_i.offset_dac_code < step_i;
  wire [5:0] up_code  = sat_hi ? CSI_DAC_CODE_MAX : sum[5:0];
  wire [5:0] dn_code  = sat_lo ? CSI_DAC_CODE_MIN : cur_i.offset_dac_code - step_i;

  wire [5:0] next_code = go_up ? up_code : dn_code;

  // one driver for the whole word, enable and auto bits pass through
  assign change_o = go_up | go_down;
  assign next_o   = {cur_i.offset_dac_enable, cur_i.offset_auto_adjust, next_code};

endmodule
`default_nettype wire

// ### hw/csi_slave.sv
// two-wire serial slave with register pointer, offset dac and id registers
// Operation
// - start is sda falling while scl high; detect it and expect an address byte.
// - address byte is 7-bit address plus direction bit, msb first, eight bits shifted.
// - on address match pull sda low on ninth clock; else release and wait.
// - answer address byte 0x90 for write and 0x91 for read.
// - direction bit 0 makes a slave receiver, 1 a slave transmitter.
// - first write byte after address loads the register pointer and is acknowledged.
// - stop during a write returns to idle and clears pointer to 0x00.
// - each later write byte goes to pointed register, is acknowledged, pointer advances.
// - a repeated start is handled like a start, address re-received and matched.
// - a read drives the pointed register onto sda, then awaits master acknowledge.
// - master acknowledge advances the pointer and sends the next register's byte.
// - master not-acknowledge returns to idle and leaves the pointer unchanged.
// - the pointer itself is never readable; reads return pointed register contents.
// - reads at unmapped addresses keep supplying bytes until nack, start or stop.
// - stop ending a read resets the pointer to status address 0x00 (no status register here; 0x00 reads as unmapped, 0x00).
// - write to invalid address changes nothing but is still acknowledged.
// - bit 7 of each offset dac register enables that channel's dac.
// - auto-adjust steps dac code up above 3/4, down below 1/4 full range.
// - in fixed threshold mode automatic offset adjustment stays disabled.
// - both offset dac registers are read/write and reset to 0xc0.
// - 32-bit read-only serial number readable over four consecutive addresses.
// - 8-bit read-only chip identification code readable at its own address.
`timescale 1ns/1ps
`default_nettype none
module csi_slave
  import csi_pkg::*;
#(
  parameter int          AVG_W         = 16,
  parameter logic [31:0] SERIAL_NUMBER = 32'h1357_9bdf, // arbitrary value
  parameter logic [7:0]  CHIP_IDENTIFICATION       = 8'h5a          // arbitrary value
) (
  input  wire logic                            clk_i,
  input  wire logic                            srst_i,
  input  wire logic                            scl_i,
  input  wire logic                            sda_i,
  output logic                                 sda_o,
  output logic                                 sda_oe_n_o,
  input  wire logic                            adaptive_mode_i,
  input  wire logic [CSI_CHANNELS-1:0]         avg_valid_i,
  input  wire logic [CSI_CHANNELS-1:0][AVG_W-1:0] avg_i,
  input  wire logic [5:0]                      dac_step_i,
  output csi_dac_type                          ch1_dac_o,
  output csi_dac_type                          ch2_dac_o
);

  logic [1:0]        scl_sync;
  logic [1:0]        sda_sync;
  logic              scl_q;
  logic              sda_q;
  csi_state_type     state;
  logic [3:0]        bit_cnt;
  logic [7:0]        shift;
  logic [7:0]        ptr;
  logic [7:0]        tx;
  logic              dir_read;
  logic              mst_ack;
  logic              oe_n;
  csi_dac_type       dac [CSI_CHANNELS];
  csi_dac_type       adj_dac [CSI_CHANNELS];
  logic [CSI_CHANNELS-1:0] adj_chg;

  // byte supplied for a pointer value; the pointer itself has no address
  function automatic logic [7:0] read_reg(input logic [7:0]  a,
                                          input csi_dac_type d0,
                                          input csi_dac_type d1);
    case (a)
      CSI_OFS_CH1_DAC: read_reg = d0;
      CSI_OFS_CH2_DAC: read_reg = d1;
      CSI_OFS_SERIAL0: read_reg = SERIAL_NUMBER[31:24];
      CSI_OFS_SERIAL1: read_reg = SERIAL_NUMBER[23:16];
      CSI_OFS_SERIAL2: read_reg = SERIAL_NUMBER[15:8];
      CSI_OFS_SERIAL3: read_reg = SERIAL_NUMBER[7:0];
      CSI_OFS_CHIP_IDENTIFICATION: read_reg = CHIP_IDENTIFICATION;
      default:         read_reg = CSI_UNMAPPED_VAL;
    endcase
  endfunction

  // pin synchronisers and edge detection
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      scl_sync <= 2'h3;
      sda_sync <= 2'h3;
      scl_q    <= 1'b1;
      sda_q    <= 1'b1;
    end else begin
      scl_sync <= {scl_sync[0], scl_i};
      sda_sync <= {sda_sync[0], sda_i};
      scl_q    <= scl_sync[1];
      sda_q    <= sda_sync[1];
    end
  end

  wire       scl_s      = scl_sync[1];
  wire       sda_s      = sda_sync[1];
  wire       scl_rise   = scl_s & ~scl_q;
  wire       scl_fall   = ~scl_s & scl_q;
  wire       start_det  = scl_s & scl_q & sda_q & ~sda_s;
  wire       stop_det   = scl_s & scl_q & ~sda_q & sda_s;
  wire       byte_done  = bit_cnt == CSI_BYTE_BITS;
  wire       addr_match = shift[7:1] == CSI_DEV_ADDR;
  wire       recv_state = (state == CSI_ADDR) | (state == CSI_PTR) | (state == CSI_WDATA);
  wire       recv_end   = recv_state & scl_fall & byte_done;
  wire [7:0] next_ptr   = ptr + 8'h01;
  wire [7:0] rd_byte    = read_reg(ptr, dac[0], dac[1]);
  wire [7:0] rd_next    = read_reg(next_ptr, dac[0], dac[1]);
  wire       bus_wr     = recv_end & (state == CSI_WDATA);
  wire [CSI_CHANNELS-1:0] wr_ch = {bus_wr & (ptr == CSI_OFS_CH2_DAC),
                                   bus_wr & (ptr == CSI_OFS_CH1_DAC)};

  // serial protocol engine
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      state    <= CSI_IDLE;
      bit_cnt  <= 4'h0;
      shift    <= 8'h00;
      ptr      <= CSI_PTR_RESET;
      tx       <= 8'h00;
      dir_read <= 1'b0;
      mst_ack  <= 1'b0;
      oe_n     <= 1'b1;
    end else if (start_det) begin
      state   <= CSI_ADDR;
      bit_cnt <= 4'h0;
      oe_n    <= 1'b1;
    end else if (stop_det) begin
      state <= CSI_IDLE;
      ptr   <= CSI_PTR_RESET;
      oe_n  <= 1'b1;
    end else begin
      case (state)
        CSI_ADDR, CSI_PTR, CSI_WDATA: begin
          if (scl_rise) begin
            shift   <= {shift[6:0], sda_s};
            bit_cnt <= bit_cnt + 4'h1;
          end else if (recv_end) begin
            bit_cnt <= 4'h0;
            if (state == CSI_ADDR && !addr_match) begin
              state <= CSI_IDLE;
            end else begin
              oe_n <= 1'b0;
              if (state == CSI_ADDR) begin
                state    <= CSI_ADDR_ACK;
                dir_read <= shift[0] != CSI_DIR_WRITE;
              end else begin
                state <= CSI_WR_ACK;
              end
              if (state == CSI_PTR) begin
                ptr <= shift;
              end
              if (state == CSI_WDATA) begin
                ptr <= next_ptr;
              end
            end
          end
        end
        CSI_ADDR_ACK: begin
          if (scl_fall) begin
            if (dir_read) begin
              state <= CSI_RDATA;
              tx    <= rd_byte;
              oe_n  <= rd_byte[7];
            end else begin
              state <= CSI_PTR;
              oe_n  <= 1'b1;
            end
          end
        end
        CSI_WR_ACK: begin
          if (scl_fall) begin
            state <= CSI_WDATA;
            oe_n  <= 1'b1;
          end
        end
        CSI_RDATA: begin
          if (scl_rise) begin
            bit_cnt <= bit_cnt + 4'h1;
          end else if (scl_fall) begin
            if (byte_done) begin
              bit_cnt <= 4'h0;
              oe_n    <= 1'b1;
              state   <= CSI_RD_ACK;
            end else begin
              tx   <= {tx[6:0], 1'b0};
              oe_n <= tx[6];
            end
          end
        end
        CSI_RD_ACK: begin
          if (scl_rise) begin
            mst_ack <= ~sda_s;
          end else if (scl_fall) begin
            if (mst_ack) begin
              ptr   <= next_ptr;
              tx    <= rd_next;
              oe_n  <= rd_next[7];
              state <= CSI_RDATA;
            end else begin
              state <= CSI_IDLE;
            end
          end
        end
        CSI_IDLE: begin
          oe_n <= 1'b1;
        end
        default: begin
          state <= CSI_IDLE;
          oe_n  <= 1'b1;
        end
      endcase
    end
  end

  // automatic offset adjustment per channel
  for (genvar c = 0; c < CSI_CHANNELS; c++) begin : g_adj
    csi_dac_adjust #(
      .AVG_W (AVG_W)
    ) u_adj (
      .avg_i       (avg_i[c]),
      .avg_valid_i (avg_valid_i[c]),
      .adaptive_i  (adaptive_mode_i),
      .step_i      (dac_step_i),
      .cur_i       (dac[c]),
      .next_o      (adj_dac[c]),
      .change_o    (adj_chg[c])
    );
  end

  // offset dac registers, bus write takes priority over adjustment
  always_ff @(posedge clk_i) begin
    for (int c = 0; c < CSI_CHANNELS; c++) begin
      if (srst_i) begin
        dac[c] <= CSI_DAC_RESET;
      end else if (wr_ch[c]) begin
        dac[c] <= shift;
      end else if (adj_chg[c]) begin
        dac[c] <= adj_dac[c];
      end
    end
  end

  // open-drain pin: data fixed low, enable active low
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      sda_o      <= 1'b0;
      sda_oe_n_o <= 1'b1;
    end else begin
      sda_o      <= 1'b0;
      sda_oe_n_o <= oe_n;
    end
  end

  // enable and code fields go to the analog dac per channel
  assign ch1_dac_o = dac[0];
  assign ch2_dac_o = dac[1];

  // checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);

  start_to_addr_a: assert property (start_det |=> state == CSI_ADDR && bit_cnt == 4'h0)
    else $error("start not followed by address phase");

  stop_clears_ptr_a: assert property (stop_det |=> ptr == CSI_PTR_RESET && state == CSI_IDLE)
    else $error("stop did not clear pointer");

  read_stop_ptr_a: assert property (stop_det && dir_read |=> ptr == CSI_PTR_RESET)
    else $error("stop after read did not reset pointer");

  nomatch_release_a: assert property (recv_end && state == CSI_ADDR && !addr_match
                                      |=> state == CSI_IDLE ##1 sda_oe_n_o)
    else $error("unmatched address was not ignored");

  match_ack_a: assert property (recv_end && state == CSI_ADDR && addr_match
                                |=> ##1 !sda_oe_n_o)
    else $error("matched address not acknowledged");

  read_dir_a: assert property (recv_end && state == CSI_ADDR && addr_match
                               |=> dir_read == $past(shift[0]))
    else $error("direction bit not taken");

  ptr_load_a: assert property (recv_end && state == CSI_PTR |=> ptr == $past(shift))
    else $error("pointer byte not loaded");

  write_store_a: assert property (bus_wr && ptr == CSI_OFS_CH1_DAC
                                  |=> ch1_dac_o == $past(shift) && ptr == $past(next_ptr))
    else $error("write byte not stored or pointer not advanced");

  invalid_write_a: assert property (bus_wr && ptr != CSI_OFS_CH1_DAC && ptr != CSI_OFS_CH2_DAC
                                    && adj_chg == 2'h0
                                    |=> $stable(ch1_dac_o) && $stable(ch2_dac_o) ##1 !sda_oe_n_o)
    else $error("invalid write changed a register or was not acknowledged");

  nack_idle_a: assert property (state == CSI_RD_ACK && scl_fall && !mst_ack && !start_det && !stop_det
                                |=> state == CSI_IDLE && $stable(ptr))
    else $error("nack did not end read with pointer held");

  ack_next_a: assert property (state == CSI_RD_ACK && scl_fall && mst_ack && !start_det && !stop_det
                               |=> state == CSI_RDATA && ptr == $past(next_ptr) && tx == $past(rd_next))
    else $error("ack did not advance to next byte");

  fixed_mode_a: assert property (!adaptive_mode_i && wr_ch == 2'h0 |=> $stable(ch1_dac_o) && $stable(ch2_dac_o))
    else $error("offset adjusted in fixed threshold mode");

  idle_release_a: assert property (state == CSI_IDLE ##1 state == CSI_IDLE |-> ##1 sda_oe_n_o)
    else $error("sda driven while idle");

  start_release_a: assert property (start_det |=> ##1 sda_oe_n_o)
    else $error("sda driven after start");

  bit_count_a: assert property (recv_state |-> bit_cnt <= CSI_BYTE_BITS)
    else $error("receive bit count beyond one byte");

  ch2_store_a: assert property (bus_wr && ptr == CSI_OFS_CH2_DAC |=> ch2_dac_o == $past(shift))
    else $error("channel 2 write byte not stored");

  wr_release_a: assert property (state == CSI_WR_ACK && scl_fall && !start_det && !stop_det
                                 |=> state == CSI_WDATA ##1 sda_oe_n_o)
    else $error("write acknowledge not released");

  tx_load_a: assert property (state == CSI_ADDR_ACK && scl_fall && dir_read && !start_det && !stop_det
                              |=> state == CSI_RDATA && tx == $past(rd_byte))
    else $error("read byte not loaded after address");

  rd_release_a: assert property (state == CSI_RDATA && scl_fall && byte_done && !start_det && !stop_det
                                 |=> state == CSI_RD_ACK ##1 sda_oe_n_o)
    else $error("sda not released for master acknowledge");

  adjust_up_a: assert property (adaptive_mode_i && avg_valid_i[0] && ch1_dac_o.offset_auto_adjust
                                && dac_step_i != 6'h00 && !wr_ch[0] && avg_i[0] > (AVG_W'(3) << (AVG_W - 2))
                                |=> ch1_dac_o.offset_dac_code > $past(ch1_dac_o.offset_dac_code)
                                    || ch1_dac_o.offset_dac_code == CSI_DAC_CODE_MAX)
    else $error("offset code not stepped up");

  adjust_down_a: assert property (adaptive_mode_i && avg_valid_i[0] && ch1_dac_o.offset_auto_adjust
                                  && dac_step_i != 6'h00 && !wr_ch[0] && avg_i[0] < (AVG_W'(1) << (AVG_W - 2))
                                  |=> ch1_dac_o.offset_dac_code < $past(ch1_dac_o.offset_dac_code)
                                      || ch1_dac_o.offset_dac_code == CSI_DAC_CODE_MIN)
    else $error("offset code not stepped down");

  write_cv: cover property (bus_wr ##[1:200] stop_det);
  read_cv:  cover property (state == CSI_RD_ACK && scl_fall && mst_ack ##[1:400] state == CSI_RD_ACK);
  rstart_cv: cover property (state == CSI_WDATA ##[1:40] start_det);
  adjust_cv: cover property (adj_chg != 2'h0);
  nack_cv:   cover property (state == CSI_RD_ACK && scl_fall && !mst_ack);

endmodule
`default_nettype wire

// ### tb/csi_bus_master.sv
// two-wire bus master model that drives the slave's serial pins
`timescale 1ns/1ps
`default_nettype none
module csi_bus_master (
  input  wire logic clk_i,
  input  wire logic sda_i,
  output var  logic scl_o,
  output var  logic sda_o
);
  // extra low-phase cycles per bit, for a slow master
  int unsigned stretch = 0;

  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end

  task automatic tick(input int n);
    repeat (n) @(negedge clk_i);
  endtask

  // start or repeated start: sda falls while scl high
  task automatic start_cond();
    sda_o = 1'b1;
    tick(2);
    scl_o = 1'b1;
    tick(4);
    sda_o = 1'b0;
    tick(4);
    scl_o = 1'b0;
    tick(2);
  endtask

  // stop: sda rises while scl high
  task automatic stop_cond();
    sda_o = 1'b0;
    tick(2);
    scl_o = 1'b1;
    tick(4);
    sda_o = 1'b1;
    tick(4);
  endtask

  // data changes only while scl low, sampled late in the high phase
  task automatic bit_xfer(input logic b, output logic r);
    sda_o = b;
    tick(2 + stretch);
    scl_o = 1'b1;
    tick(3);
    r = sda_i;
    tick(1);
    scl_o = 1'b0;
    tick(2);
  endtask

  task automatic send_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_xfer(d[i], r);
    end
    bit_xfer(1'b1, ack);
  endtask

  task automatic recv_byte(input logic nack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_xfer(1'b1, r);
      d[i] = r;
    end
    bit_xfer(nack, r);
  endtask
endmodule
`default_nettype wire

// ### tb/test_csi_slave.sv
// self-checking bench for the serial slave and its offset dac registers
`timescale 1ns/1ps
`default_nettype none
module test_csi_slave;
  import csi_pkg::*;
  logic                                clk_i;
  logic                                srst_i;
  logic                                adaptive_mode_i;
  logic [CSI_CHANNELS-1:0]             avg_valid_i;
  logic [CSI_CHANNELS-1:0][15:0]       avg_i;
  logic [5:0]                          dac_step_i;
  logic                                sda_o;
  logic                                sda_oe_n_o;
  csi_dac_type                         ch1_dac_o;
  csi_dac_type                         ch2_dac_o;
  logic                                scl_line;
  logic                                master_sda;
  wire logic                           sda_line;
  int                                  failures = 0;
  int                                  n_compared = 0;
  logic [23:0]                         rows [5];

  // open-drain wire with pull-up
  assign sda_line = master_sda & (sda_oe_n_o | sda_o);

  csi_slave u_csi_slave (
    .clk_i           (clk_i),
    .srst_i          (srst_i),
    .scl_i           (scl_line),
    .sda_i           (sda_line),
    .sda_o           (sda_o),
    .sda_oe_n_o      (sda_oe_n_o),
    .adaptive_mode_i (adaptive_mode_i),
    .avg_valid_i     (avg_valid_i),
    .avg_i           (avg_i),
    .dac_step_i      (dac_step_i),
    .ch1_dac_o       (ch1_dac_o),
    .ch2_dac_o       (ch2_dac_o)
  );

  csi_bus_master u_csi_bus_master (
    .clk_i (clk_i),
    .sda_i (sda_line),
    .scl_o (scl_line),
    .sda_o (master_sda)
  );

  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic conclude();
    $display("compared %0d, failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic addr_phase(input logic [7:0] a, input logic exp_ack_n);
    logic ack;
    u_csi_bus_master.start_cond();
    u_csi_bus_master.send_byte(a, ack);
    check(ack, exp_ack_n);
  endtask

  task automatic wbyte(input logic [7:0] d);
    logic ack;
    u_csi_bus_master.send_byte(d, ack);
    check(ack, 1'b0);
  endtask

  // reads all bytes, acking each but the last
  task automatic rbytes(input logic [7:0] exp_q [$]);
    logic [7:0] d;
    foreach (exp_q[i]) begin
      u_csi_bus_master.recv_byte(i == exp_q.size() - 1, d);
      check(d, exp_q[i]);
    end
  endtask

  task automatic set_ptr(input logic [7:0] p);
    addr_phase(8'h90, 1'b0);
    wbyte(p);
  endtask

  task automatic pulse(input logic [1:0] v, input logic [15:0] a);
    avg_i = {a, a};
    avg_valid_i = v;
    @(negedge clk_i);
    avg_valid_i = 2'h0;
    repeat (2) @(negedge clk_i);
  endtask

  initial begin
    logic [7:0] p;
    logic [7:0] w;
    logic [7:0] e;
    rows = '{24'h11_85_85, 24'h12_3f_3f, 24'h13_aa_13, 24'h17_00_5a, 24'h05_77_00};
    srst_i = 1'b1;
    adaptive_mode_i = 1'b0;
    avg_valid_i = 2'h0;
    avg_i = '0;
    dac_step_i = 6'h05;
    repeat (16) @(negedge clk_i);
    srst_i = 1'b0;
    check(ch1_dac_o, 8'hc0);
    check(ch2_dac_o, 8'hc0);
    check(sda_oe_n_o, 1'b1);
    repeat (4) @(negedge clk_i);
    $display("test done: reset");
    // offset dac auto adjust
    pulse(2'h1, 16'hffff);
    check(ch1_dac_o, 8'hc0);
    adaptive_mode_i = 1'b1;
    pulse(2'h1, 16'hffff);
    check(ch1_dac_o, 8'hc5);
    pulse(2'h1, 16'h8000);
    check(ch1_dac_o, 8'hc5);
    pulse(2'h1, 16'h0001);
    pulse(2'h1, 16'h0001);
    check(ch1_dac_o, 8'hc0);
    for (int i = 0; i < 13; i++) pulse(2'h2, 16'hffff);
    check(ch2_dac_o, 8'hff);
    $display("test done: auto adjust");
    // table: write a register, then read it back through a repeated start
    foreach (rows[i]) begin
      {p, w, e} = rows[i];
      set_ptr(p);
      wbyte(w);
      u_csi_bus_master.stop_cond();
      set_ptr(p);
      addr_phase(8'h91, 1'b0);
      rbytes('{e});
      u_csi_bus_master.stop_cond();
      $display("test done: row %0d", i);
    end
    check(ch1_dac_o, 8'h85);
    check(ch2_dac_o, 8'h3f);
    // wrong address gets no acknowledge
    addr_phase(8'h92, 1'b1);
    u_csi_bus_master.stop_cond();
    addr_phase(8'h90, 1'b0);
    u_csi_bus_master.stop_cond();
    $display("test done: wrong address");
    // block write with a slow master
    u_csi_bus_master.stretch = 6;
    set_ptr(8'h11);
    wbyte(8'h01);
    wbyte(8'h02);
    u_csi_bus_master.stop_cond();
    u_csi_bus_master.stretch = 0;
    check(ch1_dac_o, 8'h01);
    check(ch2_dac_o, 8'h02);
    $display("test done: block write");
    // block read across serial number, chip_identification and past the end
    set_ptr(8'h13);
    addr_phase(8'h91, 1'b0);
    rbytes('{8'h13, 8'h57, 8'h9b, 8'hdf, 8'h5a, 8'h00});
    u_csi_bus_master.stop_cond();
    $display("test done: block read");
    // stop after a pointer write clears the pointer
    set_ptr(8'h17);
    u_csi_bus_master.stop_cond();
    addr_phase(8'h91, 1'b0);
    rbytes('{8'h00});
    u_csi_bus_master.stop_cond();
    $display("test done: stop after write");
    // nack keeps the pointer, stop after a read clears it
    set_ptr(8'h14);
    addr_phase(8'h91, 1'b0);
    rbytes('{8'h57});
    addr_phase(8'h91, 1'b0);
    rbytes('{8'h57});
    u_csi_bus_master.stop_cond();
    addr_phase(8'h91, 1'b0);
    rbytes('{8'h00});
    u_csi_bus_master.stop_cond();
    check(sda_oe_n_o, 1'b1);
    $display("test done: nack and stop after read");
    // reset in mid-run restores the dac registers and the pointer
    set_ptr(8'h11);
    srst_i = 1'b1;
    repeat (2) @(negedge clk_i);
    srst_i = 1'b0;
    check(ch1_dac_o, 8'hc0);
    check(ch2_dac_o, 8'hc0);
    check(sda_oe_n_o, 1'b1);
    check(sda_o, 1'b0);
    repeat (4) @(negedge clk_i);
    addr_phase(8'h91, 1'b0);
    rbytes('{8'h00});
    u_csi_bus_master.stop_cond();
    $display("test done: mid-run reset");
    conclude();
  end

  initial begin
    repeat (60000) @(posedge clk_i);
    failures++;
    conclude();
  end
endmodule
`default_nettype wire
